// [logic/led_flash_mode_control.sv]
// Control registers and mode sequencing of the flash LED driver
//
// Behaviour
// RULE1 - Level strobe usage: flash lasts while trigger active; edge: internal timing.
// RULE2 - Config bits 6,5,4 set polarity of flash, torch and tx inputs.
// RULE3 - Tx event moves current to torch level if level bit set, else off.
// RULE4 - Tx off setting forces shutdown only during a flash event.
// RULE5 - Tx event with off level in torch or indicator keeps running.
// RULE6 - That case sets tx flag and locks mode bits until flags read.
// RULE7 - Host should clear tx enable before reading flags.
// RULE8 - Config bit 2 enables input voltage flash monitoring; reset off.
// RULE9 - Config bit 1 set makes thermistor trip report only.
// RULE10 - Config bit 0 selects internal PWM or external indicator pattern.
// RULE11 - Flash ramp field doubles from 256 us; reset code 010.
// RULE12 - Flash time-out 100 ms per code plus one; reset code 010.
// RULE13 - Enable bit 6 lets tx events alter current; else ignored.
// RULE14 - Enable bit 5 lets flash trigger input start a flash.
// RULE15 - Enable bit 4 lets torch input start a torch event.
// RULE16 - Enable bit 3 selects pre-charge via pass mode.
// RULE17 - Enable bit 2 restricts converter to pass operation.
// RULE18 - Pass-only taken in an LED mode persists until standby.
// RULE19 - Mode field: 00 standby, 01 indicator, 10 torch, 11 flash.
// RULE20 - Torch written with torch input disabled starts immediately.
// RULE21 - Flash written with trigger input disabled starts immediately.
// RULE22 - Flag read clears flags; they set again if condition persists.
// RULE23 - Time-out flag set when flash timer expires before flash ends.
// RULE24 - Flash time-out ends flash and returns mode field to standby.
// RULE25 - Reserved bits read zero; registers load defaults on reset.
`timescale 1ns/1ps
`default_nettype none
module led_flash_mode_control
  import led_flash_pkg::*;
#(
  parameter int unsigned TOUT_STEP = TOUT_STEP_CYC,
  parameter int unsigned RAMP_BASE = RAMP_BASE_CYC
) (
  input  wire logic     clk,
  input  wire logic     rstn,
  input  wire reg_req_t req,
  input  wire logic     flash_trig_pin,
  input  wire logic     torch_pin,
  input  wire logic     tx_pin,
  input  wire logic     ntc_trip,
  input  wire logic     input_voltage_flash_monitor_trip,
  output logic [7:0]    rdata,
  output drive_t        drive,
  output logic [2:0]    torch_code,
  output logic [3:0]    flash_code
);
  logic [7:0] cfg_r;
  logic [7:0] fcfg_r;
  logic [7:0] cur_r;
  logic [7:0] en_r;
  logic [7:0] flags_r;
  logic [1:0] mode_r;
  logic       active_r;
  logic       pass_latch_r;
  logic       tx_hold_r;
  logic [31:0] tmr_r;
  logic [31:0] ramp_r;
  logic       ramping_r;
  logic       lock;
  logic       str_lvl, str_rise, tor_rise, tx_rise;
  logic       flash_on, tout_hit, tx_ev, tx_lock_ev, ntc_ev;
  logic [31:0] tout_lim;
  logic [31:0] ramp_lim;

  // Pin synchronisers with per-pin polarity
  sync_edge u_str (.clk(clk), .rstn(rstn), .pin(flash_trig_pin),
    .active_high(cfg_r[CFG_STR_POL_POS]), .level(str_lvl), .rise(str_rise)); // RULE2
  sync_edge u_tor (.clk(clk), .rstn(rstn), .pin(torch_pin),
    .active_high(cfg_r[CFG_TOR_POL_POS]), .level(), .rise(tor_rise)); // RULE2
  sync_edge u_tx (.clk(clk), .rstn(rstn), .pin(tx_pin),
    .active_high(cfg_r[CFG_TX_POL_POS]), .level(), .rise(tx_rise)); // RULE2

  // Time-out and ramp limits from the field codes
  assign tout_lim = 32'(TOUT_STEP) * (32'(fcfg_r[TOUT_LSB +: 3]) + 32'd1); // RULE12
  assign ramp_lim = 32'(RAMP_BASE) << fcfg_r[RAMP_LSB +: 3]; // RULE11
  assign flash_on = active_r && (mode_r == MODE_FLASH);
  assign tout_hit = flash_on && (tmr_r >= tout_lim - 32'd1);
  assign tx_ev    = tx_rise && en_r[EN_TX_POS]; // RULE13
  // Off-level tx in torch/indicator only flags and locks
  assign tx_lock_ev = tx_ev && !cfg_r[CFG_TX_LVL_POS] && active_r &&
                      (mode_r == MODE_TORCH || mode_r == MODE_INDICATOR); // RULE5
  assign ntc_ev   = ntc_trip && en_r[EN_NTC_POS];
  assign lock     = flags_r[FLG_TX_POS]; // RULE6

  // Configuration registers; reserved bit 7 of current is dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r  <= CFG_RESET; // RULE25
      fcfg_r <= FLASH_CFG_RESET;
      cur_r  <= CURRENT_RESET;
    end else if (req.wr) begin
      if (req.addr == OFF_PIN_CFG)   cfg_r  <= req.wdata;
      if (req.addr == OFF_FLASH_CFG) fcfg_r <= req.wdata;
      if (req.addr == OFF_CURRENT)   cur_r  <= req.wdata & CURRENT_MASK; // RULE25
    end
  end

  // Enable register; mode bits frozen while tx flag stands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_r   <= ENABLE_RESET;
      mode_r <= MODE_STANDBY;
    end else begin
      if (req.wr && req.addr == OFF_ENABLE) begin
        en_r <= req.wdata;
        if (!lock) mode_r <= req.wdata[1:0]; // RULE6
      end
      if (tout_hit) mode_r <= MODE_STANDBY; // RULE24
      else if (flash_on && tx_ev && !cfg_r[CFG_TX_LVL_POS])
        mode_r <= MODE_STANDBY; // RULE4
      else if (flash_on && cfg_r[CFG_LEVEL_POS] && !str_lvl &&
               en_r[EN_STR_POS])
        mode_r <= MODE_STANDBY; // RULE1
    end
  end

  // Event start: register write or enabled pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_r <= 1'b0;
    end else if (mode_r == MODE_STANDBY) begin
      active_r <= 1'b0; // RULE19
    end else if (!active_r) begin
      unique case (mode_r)
        MODE_INDICATOR: active_r <= 1'b1;
        MODE_TORCH: active_r <= en_r[EN_TOR_POS] ? tor_rise : 1'b1; // RULE15 RULE20
        MODE_FLASH: active_r <= en_r[EN_STR_POS] ? str_rise : 1'b1; // RULE14 RULE21
        MODE_STANDBY: active_r <= 1'b0;
      endcase
    end
  end

  // Flash timer and ramp timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_r     <= '0;
      ramp_r    <= '0;
      ramping_r <= 1'b0;
    end else if (!active_r) begin
      tmr_r     <= '0;
      ramp_r    <= '0;
      ramping_r <= 1'b1;
    end else begin
      // Level strobe: time-out still guards a stuck trigger
      tmr_r <= flash_on ? tmr_r + 32'd1 : '0;
      if (ramp_r >= ramp_lim - 32'd1) ramping_r <= 1'b0;
      else ramp_r <= ramp_r + 32'd1;
    end
  end

  // Tx hold: drop to torch current for rest of flash
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) tx_hold_r <= 1'b0;
    else if (!flash_on) tx_hold_r <= 1'b0;
    else if (tx_ev && cfg_r[CFG_TX_LVL_POS]) tx_hold_r <= 1'b1; // RULE3
  end

  // Pass-only latch held until standby
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pass_latch_r <= 1'b0;
    else if (mode_r == MODE_STANDBY) pass_latch_r <= 1'b0;
    else if (active_r && en_r[EN_PASS_POS]) pass_latch_r <= 1'b1; // RULE18
  end

  // Flags: a read clears; a new event in the same cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= '0;
    end else begin
      if (req.rd && req.addr == OFF_FLAGS) flags_r <= '0; // RULE22
      if (tx_lock_ev) flags_r[FLG_TX_POS] <= 1'b1; // RULE6
      if (ntc_ev) flags_r[FLG_NTC_POS] <= 1'b1;
      if (input_voltage_flash_monitor_trip && cfg_r[CFG_INPUT_VOLTAGE_FLASH_MONITOR_POS] && flash_on)
        flags_r[FLG_INPUT_VOLTAGE_FLASH_MONITOR_POS] <= 1'b1;
      if (tout_hit) flags_r[FLG_TOUT_POS] <= 1'b1; // RULE23
    end
  end

  // Read data, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (req.rd) begin
      unique case (req.addr)
        OFF_PIN_CFG:   rdata <= cfg_r;
        OFF_FLASH_CFG: rdata <= fcfg_r;
        OFF_CURRENT:   rdata <= cur_r; // RULE25
        OFF_ENABLE:    rdata <= {en_r[7:2], mode_r};
        OFF_FLAGS:     rdata <= flags_r;
        default:       rdata <= '0;
      endcase
    end
  end

  // Analog drive requests, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive      <= '0;
      torch_code <= '0;
      flash_code <= '0;
    end else begin
      drive.led_on       <= active_r && !(ntc_ev && !cfg_r[CFG_NTC_MON_POS]); // RULE9
      drive.torch_level  <= tx_hold_r || mode_r == MODE_TORCH;
      drive.ramping      <= active_r && ramping_r;
      drive.pass_only    <= en_r[EN_PASS_POS] || pass_latch_r; // RULE17
      drive.precharge    <= en_r[EN_PRE_POS]; // RULE16
      drive.input_voltage_flash_monitor_on      <= cfg_r[CFG_INPUT_VOLTAGE_FLASH_MONITOR_POS]; // RULE8
      drive.ntc_on       <= en_r[EN_NTC_POS];
      drive.ind_external <= cfg_r[CFG_IND_EXT_POS]; // RULE10
      torch_code         <= cur_r[6:4];
      flash_code         <= cur_r[3:0];
    end
  end

  // Time-out ends flash within one cycle and sets flag
  timeout_a: assert property (@(posedge clk) disable iff (!rstn) // RULE24
    tout_hit |=> mode_r == MODE_STANDBY && flags_r[FLG_TOUT_POS])
    else $error("time-out did not end flash");
  // Mode bits hold while tx lock stands
  mode_lock_a: assert property (@(posedge clk) disable iff (!rstn) // RULE6
    lock && !tout_hit && !flash_on |=> $stable(mode_r))
    else $error("mode changed under tx lock");
  // Flag read clears unless an event re-sets
  flag_clear_a: assert property (@(posedge clk) disable iff (!rstn) // RULE22
    req.rd && req.addr == OFF_FLAGS && !tx_lock_ev && !ntc_ev && !tout_hit
    && !input_voltage_flash_monitor_trip |=> flags_r == '0)
    else $error("flags not cleared by read");
  // Register write of torch starts torch with pin disabled
  torch_start_a: assert property (@(posedge clk) disable iff (!rstn) // RULE20
    mode_r == MODE_TORCH && !en_r[EN_TOR_POS] && !active_r |=> active_r)
    else $error("torch did not start");
  flash_start_a: assert property (@(posedge clk) disable iff (!rstn) // RULE21
    mode_r == MODE_FLASH && !en_r[EN_STR_POS] && !active_r |=> active_r)
    else $error("flash did not start");
  pin_gate_a: assert property (@(posedge clk) disable iff (!rstn) // RULE14
    mode_r == MODE_FLASH && en_r[EN_STR_POS] && !active_r && !str_rise
    |=> !active_r)
    else $error("flash started without trigger");
  pass_hold_a: assert property (@(posedge clk) disable iff (!rstn) // RULE18
    pass_latch_r && mode_r != MODE_STANDBY |=> ##1 drive.pass_only)
    else $error("pass-only dropped in LED mode");
  tx_keep_a: assert property (@(posedge clk) disable iff (!rstn) // RULE5
    tx_lock_ev |=> active_r && flags_r[FLG_TX_POS])
    else $error("tx off shut down torch");
  reserved_a: assert property (@(posedge clk) disable iff (!rstn) // RULE25
    !cur_r[7])
    else $error("reserved bit set");

  // Named steps of a transmit event inside a flash
  sequence tx_off_in_flash_s;
    flash_on && tx_ev && !cfg_r[CFG_TX_LVL_POS];
  endsequence
  sequence tx_torch_in_flash_s;
    flash_on && tx_ev && cfg_r[CFG_TX_LVL_POS];
  endsequence
  sequence torch_level_s;
    tx_hold_r ##1 drive.torch_level;
  endsequence
  // Off level cuts the flash: standby first, then the event drops
  tx_cut_a: assert property (@(posedge clk) disable iff (!rstn) // RULE4
    tx_off_in_flash_s |=> mode_r == MODE_STANDBY ##1 !active_r)
    else $error("tx off did not end flash");
  // Torch level keeps the LED at torch current for the rest of the flash
  tx_torch_a: assert property (@(posedge clk) disable iff (!rstn) // RULE3
    tx_torch_in_flash_s |=> torch_level_s)
    else $error("tx did not drop to torch level");
  // Neither tx reaction may appear while its enable is clear
  tx_gate_a: assert property (@(posedge clk) disable iff (!rstn) // RULE13
    $rose(tx_hold_r) || $rose(flags_r[FLG_TX_POS])
    |-> $past(en_r[EN_TX_POS]))
    else $error("tx acted while disabled");

  // Level strobe: trigger release ends the flash, then the LED request
  sequence trig_released_s;
    flash_on && cfg_r[CFG_LEVEL_POS] && en_r[EN_STR_POS] && !str_lvl;
  endsequence
  level_end_a: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    trig_released_s |=> mode_r == MODE_STANDBY ##1 !active_r ##1
    !drive.led_on)
    else $error("flash outlived its trigger");
  // Enabled torch pin starts the torch on its edge
  torch_pin_a: assert property (@(posedge clk) disable iff (!rstn) // RULE15
    mode_r == MODE_TORCH && en_r[EN_TOR_POS] && !active_r && tor_rise
    |=> active_r)
    else $error("torch pin did not start torch");
  // Standby leaves no event and no LED request behind
  standby_a: assert property (@(posedge clk) disable iff (!rstn) // RULE19
    mode_r == MODE_STANDBY |=> !active_r ##1 !drive.led_on)
    else $error("LED request in standby");
  // A torch write with the pin disabled takes effect at once
  sequence torch_write_s;
    req.wr && req.addr == OFF_ENABLE && !lock && !flash_on &&
    req.wdata[1:0] == MODE_TORCH && !req.wdata[EN_TOR_POS];
  endsequence
  torch_write_a: assert property (@(posedge clk) disable iff (!rstn) // RULE20
    torch_write_s |=> mode_r == MODE_TORCH ##1 active_r)
    else $error("torch write did not start torch");
  // Voltage monitor trips in a flash are flagged only when enabled
  input_voltage_flash_monitor_flag_a: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    input_voltage_flash_monitor_trip && cfg_r[CFG_INPUT_VOLTAGE_FLASH_MONITOR_POS] && flash_on |=> flags_r[FLG_INPUT_VOLTAGE_FLASH_MONITOR_POS])
    else $error("voltage monitor trip not flagged");
  // Thermistor: normal mode darkens the LED, monitor mode only reports
  ntc_cut_a: assert property (@(posedge clk) disable iff (!rstn) // RULE9
    ntc_ev && !cfg_r[CFG_NTC_MON_POS] |=> !drive.led_on)
    else $error("thermistor trip kept LED on");
  ntc_report_a: assert property (@(posedge clk) disable iff (!rstn) // RULE9
    active_r && cfg_r[CFG_NTC_MON_POS] |=> drive.led_on)
    else $error("monitor mode darkened LED");
endmodule : led_flash_mode_control
`default_nettype wire

// [logic/led_flash_pkg.sv]
// Package: register map, field positions, reset values and timing counts
package led_flash_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam logic [7:0] OFF_PIN_CFG   = 8'h07;
  localparam logic [7:0] OFF_FLASH_CFG = 8'h08;
  localparam logic [7:0] OFF_CURRENT   = 8'h09;
  localparam logic [7:0] OFF_ENABLE    = 8'h0a;
  localparam logic [7:0] OFF_FLAGS     = 8'h0b;
  // Pin/monitor configuration fields
  localparam int CFG_LEVEL_POS   = 7;
  localparam int CFG_STR_POL_POS = 6;
  localparam int CFG_TOR_POL_POS = 5;
  localparam int CFG_TX_POL_POS  = 4;
  localparam int CFG_TX_LVL_POS  = 3;
  localparam int CFG_INPUT_VOLTAGE_FLASH_MONITOR_POS    = 2;
  localparam int CFG_NTC_MON_POS = 1;
  localparam int CFG_IND_EXT_POS = 0;
  localparam logic [7:0] CFG_RESET = 8'h78;
  // Flash timing fields
  localparam int RAMP_LSB = 3;
  localparam int TOUT_LSB = 0;
  localparam logic [7:0] FLASH_CFG_RESET = 8'hd2;
  localparam logic [7:0] CURRENT_RESET   = 8'h0f;
  localparam logic [7:0] CURRENT_MASK    = 8'h7f;
  // Enable register fields
  localparam int EN_NTC_POS  = 7;
  localparam int EN_TX_POS   = 6;
  localparam int EN_STR_POS  = 5;
  localparam int EN_TOR_POS  = 4;
  localparam int EN_PRE_POS  = 3;
  localparam int EN_PASS_POS = 2;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  // Flag bits
  localparam int FLG_TX_POS   = 7;
  localparam int FLG_NTC_POS  = 6;
  localparam int FLG_INPUT_VOLTAGE_FLASH_MONITOR_POS = 5;
  localparam int FLG_TOUT_POS = 0;
  // Timing: base ramp step and time-out step
  localparam int unsigned RAMP_BASE_US = 256;
  localparam int unsigned TOUT_STEP_MS = 100;
  localparam int unsigned RAMP_BASE_CYC = RAMP_BASE_US * CLK_MHZ;
  localparam int unsigned TOUT_STEP_CYC = TOUT_STEP_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    MODE_STANDBY   = 2'b00,
    MODE_INDICATOR = 2'b01,
    MODE_TORCH     = 2'b10,
    MODE_FLASH     = 2'b11
  } mode_sel_t;

  // Register write/read port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Drive requests to the analog section
  typedef struct packed {
    logic       led_on;
    logic       torch_level;
    logic       ramping;
    logic       pass_only;
    logic       precharge;
    logic       input_voltage_flash_monitor_on;
    logic       ntc_on;
    logic       ind_external;
  } drive_t;
endpackage : led_flash_pkg

// [logic/sync_edge.sv]
// Two-flop synchroniser with polarity select and edge pulse
`timescale 1ns/1ps
`default_nettype none
module sync_edge (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin,
  input  wire logic active_high,
  output logic      level,
  output logic      rise
);
  logic s1_r;
  logic s2_r;
  logic prev_r;

  // Only s2_r reads the first stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      s1_r   <= pin;
      s2_r   <= s1_r;
      prev_r <= s2_r;
    end
  end

  // Polarity applied after synchronisation; the edge is taken from the
  // raw level, so a polarity write or the reset value cannot fake one
  assign level = active_high ? s2_r : ~s2_r;
  assign rise  = level & (s2_r ^ prev_r);
endmodule : sync_edge
`default_nettype wire

// [test/camera_host.sv]
// Partner model: host register master and camera trigger pins
`timescale 1ns/1ps
`default_nettype none
module camera_host
  import led_flash_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output reg_req_t        req,
  output logic            flash_trig_pin,
  output logic            torch_pin,
  output logic            tx_pin
);
  // Idle bus and inactive pins at time zero
  initial begin
    req = '0;
    {flash_trig_pin, torch_pin, tx_pin} = 3'h0;
  end

  // One write, held for exactly one sampling edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req <= '0;
  endtask : reg_wr

  // Read data is registered, so it is taken one edge after the request
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    v = rdata;
  endtask : reg_rd

  // Mute transmit events first, else a busy pin sets the flag again
  task automatic flag_service(input logic [7:0] en, output logic [7:0] f);
    reg_wr(OFF_ENABLE, en & 8'hbf);
    reg_rd(OFF_FLAGS, f);
  endtask : flag_service

  // Camera pins move on a clock edge: flash, torch, transmit
  task automatic pin_set(input logic [2:0] v);
    @(posedge clk);
    {flash_trig_pin, torch_pin, tx_pin} <= v;
  endtask : pin_set
endmodule : camera_host
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench of the flash LED mode control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import led_flash_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  logic       clk, rstn, flash_trig_pin, torch_pin, tx_pin;
  logic       ntc_trip, input_voltage_flash_monitor_trip;
  reg_req_t   req;
  logic [7:0] rdata, d;
  drive_t     drive;
  logic [2:0] torch_code;
  logic [3:0] flash_code;
  int         n_errors = 0;
  int         n_checks = 0;
  row_t       rows [5];
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end

  // Short counts keep the time-out within a few dozen cycles
  led_flash_mode_control #(.TOUT_STEP(10), .RAMP_BASE(4)) dut (
    .clk(clk), .rstn(rstn), .req(req), .flash_trig_pin(flash_trig_pin),
    .torch_pin(torch_pin), .tx_pin(tx_pin), .ntc_trip(ntc_trip),
    .input_voltage_flash_monitor_trip(input_voltage_flash_monitor_trip), .rdata(rdata), .drive(drive),
    .torch_code(torch_code), .flash_code(flash_code));
  camera_host host (
    .clk(clk), .rdata(rdata), .req(req), .flash_trig_pin(flash_trig_pin),
    .torch_pin(torch_pin), .tx_pin(tx_pin));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.reg_rd(a, d);
    `CHK(d, e)
  endtask : rd_chk

  // Bounded wait for the LED request to reach a level
  task automatic led_chk(input logic v, input int n);
    repeat (n) begin
      @(posedge clk);
      if (drive.led_on === v) break;
    end
    `CHK(drive.led_on, v)
  endtask : led_chk

  // Watchdog: the sequence needs well under 5000 cycles
  initial begin
    #40000;
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    ntc_trip = 1'b0;
    input_voltage_flash_monitor_trip = 1'b0;
    rows = '{'{OFF_CURRENT, 8'hff, 8'h7f}, '{OFF_FLASH_CFG, 8'h00, 8'h00},
             '{8'h0c, 8'h55, 8'h00}, '{OFF_ENABLE, 8'h80, 8'h80},
             '{OFF_PIN_CFG, 8'h7f, 8'h7f}};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(OFF_PIN_CFG, 8'h78);
    rd_chk(OFF_FLASH_CFG, 8'hd2);
    rd_chk(OFF_CURRENT, 8'h0f);
    rd_chk(OFF_ENABLE, 8'h00);
    `CHK(drive.input_voltage_flash_monitor_on, 1'b0)
    foreach (rows[i]) begin
      host.reg_wr(rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].e);
    end
    `CHK({torch_code, flash_code}, 7'h7f)
    `CHK(drive.input_voltage_flash_monitor_on, 1'b1)
    `CHK(drive.ind_external, 1'b1)
    // Flash by register, tx ignored while disabled, then time-out
    host.reg_wr(OFF_PIN_CFG, 8'h70);
    host.reg_wr(OFF_ENABLE, 8'h03);
    led_chk(1'b1, 8);
    host.pin_set(3'b001);
    led_chk(1'b1, 4);
    host.pin_set(3'b000);
    led_chk(1'b0, 40);
    rd_chk(OFF_ENABLE, 8'h00);
    rd_chk(OFF_FLAGS, 8'h01);
    rd_chk(OFF_FLAGS, 8'h00);
    // Pass-only sticks until standby
    host.reg_wr(OFF_ENABLE, 8'h0e);
    led_chk(1'b1, 8);
    `CHK(drive.pass_only, 1'b1)
    `CHK(drive.precharge, 1'b1)
    host.reg_wr(OFF_ENABLE, 8'h02);
    repeat (4) @(posedge clk);
    `CHK(drive.pass_only, 1'b1)
    `CHK(drive.precharge, 1'b0)
    host.reg_wr(OFF_ENABLE, 8'h00);
    repeat (4) @(posedge clk);
    `CHK(drive.pass_only, 1'b0)
    // Tx off level in torch: keeps running, flags, locks mode
    host.reg_wr(OFF_ENABLE, 8'h42);
    led_chk(1'b1, 8);
    host.pin_set(3'b001);
    repeat (6) @(posedge clk);
    `CHK(drive.led_on, 1'b1)
    host.pin_set(3'b000);
    host.reg_wr(OFF_ENABLE, 8'h40);
    rd_chk(OFF_ENABLE, 8'h42);
    host.flag_service(8'h40, d);
    `CHK(d[7], 1'b1)
    host.reg_wr(OFF_ENABLE, 8'h00);
    led_chk(1'b0, 8);
    // Tx off level in flash shuts down; torch level keeps it lit
    host.reg_wr(OFF_FLASH_CFG, 8'h07);
    host.reg_wr(OFF_ENABLE, 8'h43);
    led_chk(1'b1, 8);
    host.pin_set(3'b001);
    led_chk(1'b0, 8);
    host.pin_set(3'b000);
    host.flag_service(8'h00, d);
    host.reg_wr(OFF_PIN_CFG, 8'h78);
    host.reg_wr(OFF_ENABLE, 8'h43);
    led_chk(1'b1, 8);
    host.pin_set(3'b001);
    repeat (6) @(posedge clk);
    `CHK({drive.led_on, drive.torch_level}, 2'b11)
    host.pin_set(3'b000);
    led_chk(1'b0, 100);
    host.flag_service(8'h00, d);
    // Level strobe, active low, gated by its enable
    host.pin_set(3'b100);
    host.reg_wr(OFF_PIN_CFG, 8'hb8);
    host.reg_wr(OFF_ENABLE, 8'h23);
    repeat (8) @(posedge clk);
    `CHK(drive.led_on, 1'b0)
    host.pin_set(3'b000);
    led_chk(1'b1, 8);
    host.pin_set(3'b100);
    led_chk(1'b0, 8);
    // Thermistor in torch: normal mode darkens, monitor mode reports
    host.pin_set(3'b000);
    host.reg_wr(OFF_PIN_CFG, 8'h7c);
    host.reg_wr(OFF_FLASH_CFG, 8'h0f);
    host.reg_wr(OFF_ENABLE, 8'h82);
    led_chk(1'b1, 8);
    `CHK(drive.ntc_on, 1'b1)
    `CHK(drive.ramping, 1'b1)
    // Ramp code 1 with a base of 4 lasts 8 cycles
    repeat (6) @(posedge clk);
    `CHK(drive.ramping, 1'b1)
    repeat (2) @(posedge clk);
    `CHK(drive.ramping, 1'b0)
    @(posedge clk) ntc_trip <= 1'b1;
    led_chk(1'b0, 4);
    rd_chk(OFF_FLAGS, 8'h40);
    rd_chk(OFF_FLAGS, 8'h40);
    host.reg_wr(OFF_PIN_CFG, 8'h7e);
    led_chk(1'b1, 4);
    @(posedge clk) ntc_trip <= 1'b0;
    rd_chk(OFF_FLAGS, 8'h40);
    rd_chk(OFF_FLAGS, 8'h00);
    // Voltage monitor trip inside a flash, then the time-out
    host.reg_wr(OFF_ENABLE, 8'h00);
    host.reg_wr(OFF_ENABLE, 8'h03);
    led_chk(1'b1, 8);
    @(posedge clk) input_voltage_flash_monitor_trip <= 1'b1;
    @(posedge clk) input_voltage_flash_monitor_trip <= 1'b0;
    led_chk(1'b0, 100);
    rd_chk(OFF_FLAGS, 8'h21);
    // Reset in mid-run brings the defaults back
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(OFF_PIN_CFG, 8'h78);
    rd_chk(OFF_CURRENT, 8'h0f);
    rd_chk(OFF_FLASH_CFG, 8'hd2);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
